// File: src/status_led_pkg.sv
// constants and types shared by the status indicator driver
package status_led_pkg;

    // clock and pattern timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned SLOW_BLINK_HZ   = 1;
    localparam int unsigned FAST_BLINK_MS   = 100;
    localparam int unsigned FLASH_ON_MS     = 200;
    localparam int unsigned FLASH_OFF_MS    = 1000;
    localparam int unsigned NS_PER_MS       = 1_000_000;
    // half periods: each blink toggles at half of its period for a 50 % duty
    localparam int unsigned SLOW_HALF_CYC   = CLK_HZ / (2 * SLOW_BLINK_HZ);
    localparam int unsigned FAST_HALF_CYC   = (FAST_BLINK_MS / 2) * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int unsigned FLASH_ON_CYC    = FLASH_ON_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int unsigned FLASH_OFF_CYC   = FLASH_OFF_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int unsigned TIMER_W         = 24;

    // avalon register byte addresses
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ    = 4'h8;
    localparam logic [3:0] ADDR_MASK   = 4'hC;

    // control register bit positions
    localparam int unsigned CTRL_FAST_ERR = 0;
    localparam int unsigned CTRL_W        = 1;

    // event bit positions in the sticky and mask registers
    localparam int unsigned EV_PWR_FAIL = 0;
    localparam int unsigned EV_PRG_ERR  = 1;
    localparam int unsigned EV_HW_FAULT = 2;
    localparam int unsigned EV_CARD_ERR = 3;
    localparam int unsigned EV_BUS_LINK = 4;
    localparam int unsigned EV_W        = 5;

    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // can run indicator network states
    typedef enum logic [1:0] {
        CAN_STOPPED,
        CAN_PREOP,
        CAN_OPERATIONAL
    } can_state_e;

endpackage

// File: src/status_led_indicator_driver.sv
// front panel status indicator driver with avalon control and event interrupt
//
// Operation
// - power lamp steady green when supply normal, dark when abnormal
// - program lamp steady green in run state, off in stop
// - error lamp off while no error present
// - program or configuration error blinks error lamp red at 1 Hz (code: 1 Hz only while CTRL_FAST_ERR is clear, 100 ms fast blink when set)
// - hardware fault lights error lamp steadily red
// - fast red error blink toggles every 50 ms, 100 ms period
// - card lamp off with no card or after a card access failure
// - card lamp blinks green fast during a card transfer
// - card present and idle keeps card lamp steady green
// - fieldbus lamp blinks yellow while exchanging data with a slave
// - fieldbus lamp off with no physical link
// - ethernet lamp off when not connected to a network
// - can run lamp single-flashes green while can port stopped
// - can run lamp blinks green in pre-operational state
// - can run lamp steady green in operational state
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module status_led_indicator_driver
    import status_led_pkg::*;
#(
    parameter int unsigned SLOW_HALF  = SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF  = FAST_HALF_CYC,
    parameter int unsigned FLASH_ON   = FLASH_ON_CYC,
    parameter int unsigned FLASH_OFF  = FLASH_OFF_CYC
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // condition levels from other clock domains and pins
    input  wire logic        supply_ok_i,
    input  wire logic        prog_run_i,
    input  wire logic        prog_err_i,
    input  wire logic        hw_fault_i,
    input  wire logic        memory_card_present_i,
    input  wire logic        memory_card_busy_i,
    input  wire logic        memory_card_fail_i,
    input  wire logic        fbus_link_i,
    input  wire logic        fbus_slave_cfg_i,
    input  wire logic        fbus_xfer_i,
    input  wire logic        eth_link_i,
    input  wire logic        eth_active_i,
    input  wire logic [1:0]  can_state_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // indicators and interrupt
    output logic             led_pwr_grn_o,
    output logic             led_run_grn_o,
    output logic             led_err_red_o,
    output logic             led_card_grn_o,
    output logic             led_fbus_yel_o,
    output logic             led_eth_yel_o,
    output logic             led_can_grn_o,
    output logic             irq_o
);

    if (SLOW_HALF < 1 || FAST_HALF < 1 || FLASH_ON < 1 || FLASH_OFF < 1 ||
        SLOW_HALF >= (1 << TIMER_W) || FAST_HALF >= (1 << TIMER_W) ||
        FLASH_ON >= (1 << TIMER_W) || FLASH_OFF >= (1 << TIMER_W))
    begin
        $error("status_led_indicator_driver: timing parameter out of range");
    end

    localparam int unsigned NSYNC = 14;

    // ---------------- two-flop synchronisers ----------------
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic [NSYNC-1:0] meta_nxt;
    logic [NSYNC-1:0] sync_nxt;

    assign raw_in = {can_state_i, eth_active_i, eth_link_i, fbus_xfer_i, fbus_slave_cfg_i,
                     fbus_link_i, memory_card_fail_i, memory_card_busy_i,
                     memory_card_present_i, hw_fault_i, prog_err_i, prog_run_i,
                     supply_ok_i};

    always_comb
    begin
        meta_nxt = raw_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    logic       s_supply;
    logic       s_run;
    logic       s_prg_err;
    logic       s_hw_fault;
    logic       s_card_in;
    logic       s_card_busy;
    logic       s_card_fail;
    logic       s_fb_link;
    logic       s_fb_cfg;
    logic       s_fb_xfer;
    logic       s_eth_link;
    logic       s_eth_act;
    logic [1:0] s_can;

    assign s_supply    = sync_r[0];
    assign s_run       = sync_r[1];
    assign s_prg_err   = sync_r[2];
    assign s_hw_fault  = sync_r[3];
    assign s_card_in   = sync_r[4];
    assign s_card_busy = sync_r[5];
    assign s_card_fail = sync_r[6];
    assign s_fb_link   = sync_r[7];
    assign s_fb_cfg    = sync_r[8];
    assign s_fb_xfer   = sync_r[9];
    assign s_eth_link  = sync_r[10];
    assign s_eth_act   = sync_r[11];
    assign s_can       = sync_r[13:12];

    // ---------------- shared rate generators ----------------
    // one set of generators for every lamp keeps all blinks in phase
    logic [TIMER_W-1:0] slow_cnt_r;
    logic [TIMER_W-1:0] fast_cnt_r;
    logic [TIMER_W-1:0] flash_cnt_r;
    logic               slow_ph_r;
    logic               fast_ph_r;
    logic               flash_ph_r;
    logic [TIMER_W-1:0] slow_cnt_nxt;
    logic [TIMER_W-1:0] fast_cnt_nxt;
    logic [TIMER_W-1:0] flash_cnt_nxt;
    logic               slow_ph_nxt;
    logic               fast_ph_nxt;
    logic               flash_ph_nxt;

    always_comb
    begin
        slow_cnt_nxt  = slow_cnt_r + 1'b1;
        slow_ph_nxt   = slow_ph_r;
        fast_cnt_nxt  = fast_cnt_r + 1'b1;
        fast_ph_nxt   = fast_ph_r;
        flash_cnt_nxt = flash_cnt_r + 1'b1;
        flash_ph_nxt  = flash_ph_r;
        if (slow_cnt_r == TIMER_W'(SLOW_HALF - 1))
        begin
            slow_cnt_nxt = '0;
            slow_ph_nxt  = ~slow_ph_r;
        end
        if (fast_cnt_r == TIMER_W'(FAST_HALF - 1))
        begin
            fast_cnt_nxt = '0;
            fast_ph_nxt  = ~fast_ph_r;
        end
        if (flash_ph_r && flash_cnt_r == TIMER_W'(FLASH_ON - 1))
        begin
            flash_cnt_nxt = '0;
            flash_ph_nxt  = 1'b0;
        end
        else if (!flash_ph_r && flash_cnt_r == TIMER_W'(FLASH_OFF - 1))
        begin
            flash_cnt_nxt = '0;
            flash_ph_nxt  = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            slow_cnt_r  <= '0;
            fast_cnt_r  <= '0;
            flash_cnt_r <= '0;
            slow_ph_r   <= 1'b1;
            fast_ph_r   <= 1'b1;
            flash_ph_r  <= 1'b1;
        end
        else
        begin
            slow_cnt_r  <= slow_cnt_nxt;
            fast_cnt_r  <= fast_cnt_nxt;
            flash_cnt_r <= flash_cnt_nxt;
            slow_ph_r   <= slow_ph_nxt;
            fast_ph_r   <= fast_ph_nxt;
            flash_ph_r  <= flash_ph_nxt;
        end
    end

    // ---------------- registers ----------------
    logic [CTRL_W-1:0] ctrl_r;
    logic [EV_W-1:0]   irq_stat_r;
    logic [EV_W-1:0]   irq_mask_r;
    logic [EV_W-1:0]   ev_prev_r;
    logic [31:0]       rdata_r;
    logic              wait_r;
    logic [CTRL_W-1:0] ctrl_nxt;
    logic [EV_W-1:0]   irq_stat_nxt;
    logic [EV_W-1:0]   irq_mask_nxt;
    logic [31:0]       rdata_nxt;
    logic              wait_nxt;
    logic [EV_W-1:0]   ev_now;
    logic [EV_W-1:0]   ev_rise;
    logic              access;

    // raised when a fault condition appears, dropped fieldbus link counts too
    assign ev_now = {~s_fb_link, s_card_fail, s_hw_fault, s_prg_err, ~s_supply};
    assign ev_rise = ev_now & ~ev_prev_r;
    // waitrequest is high by default; one wait state gives registered read data
    assign access = (avs_read || avs_write) && wait_r;

    always_comb
    begin
        ctrl_nxt     = ctrl_r;
        irq_mask_nxt = irq_mask_r;
        rdata_nxt    = rdata_r;
        wait_nxt     = 1'b1;
        irq_stat_nxt = irq_stat_r;
        if (access)
        begin
            wait_nxt = 1'b0;
            if (avs_write)
            begin
                case (avs_address)
                    ADDR_CTRL: ctrl_nxt = avs_writedata[CTRL_W-1:0];
                    ADDR_IRQ:  irq_stat_nxt = irq_stat_r & ~avs_writedata[EV_W-1:0];
                    ADDR_MASK: irq_mask_nxt = avs_writedata[EV_W-1:0];
                    default:   ;
                endcase
            end
            else
            begin
                case (avs_address)
                    ADDR_CTRL:   rdata_nxt = 32'(ctrl_r);
                    ADDR_STATUS: rdata_nxt = 32'({s_can, s_eth_link, s_fb_xfer, s_fb_link,
                                                  s_card_in, s_hw_fault, s_prg_err, s_run,
                                                  s_supply});
                    ADDR_IRQ:    rdata_nxt = 32'(irq_stat_r);
                    ADDR_MASK:   rdata_nxt = 32'(irq_mask_r);
                    default:     rdata_nxt = RD_UNMAPPED;
                endcase
            end
        end
        // a new event wins over a clear in the same cycle
        irq_stat_nxt = irq_stat_nxt | ev_rise;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_r     <= '0;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            ev_prev_r  <= '1; // cleared synchronisers read as lost supply and link: no event
            rdata_r    <= '0;
            wait_r     <= 1'b1;
        end
        else
        begin
            ctrl_r     <= ctrl_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            ev_prev_r  <= ev_now;
            rdata_r    <= rdata_nxt;
            wait_r     <= wait_nxt;
        end
    end

    // ---------------- lamp patterns ----------------
    logic [6:0] led_nxt;
    logic [6:0] led_r;
    logic       irq_r;
    logic       irq_nxt;

    always_comb
    begin
        led_nxt[0] = s_supply;
        led_nxt[1] = s_run;
        if (s_hw_fault)
            led_nxt[2] = 1'b1;
        else if (s_prg_err)
            led_nxt[2] = ctrl_r[CTRL_FAST_ERR] ? fast_ph_r : slow_ph_r;
        else
            led_nxt[2] = 1'b0;
        if (!s_card_in || s_card_fail)
            led_nxt[3] = 1'b0;
        else if (s_card_busy)
            led_nxt[3] = fast_ph_r;
        else
            led_nxt[3] = 1'b1;
        if (!s_fb_link)
            led_nxt[4] = 1'b0;
        else if (s_fb_cfg && s_fb_xfer)
            led_nxt[4] = slow_ph_r;
        else
            led_nxt[4] = 1'b1;
        led_nxt[5] = s_eth_link && !s_eth_act ? 1'b1 : (s_eth_link ? fast_ph_r : 1'b0);
        case (can_state_e'(s_can))
            CAN_STOPPED:     led_nxt[6] = flash_ph_r;
            CAN_PREOP:       led_nxt[6] = slow_ph_r;
            CAN_OPERATIONAL: led_nxt[6] = 1'b1;
            default:         led_nxt[6] = 1'b0;
        endcase
        irq_nxt = |(irq_stat_r & irq_mask_r);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            led_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            led_r <= led_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign led_pwr_grn_o   = led_r[0];
    assign led_run_grn_o   = led_r[1];
    assign led_err_red_o   = led_r[2];
    assign led_card_grn_o  = led_r[3];
    assign led_fbus_yel_o  = led_r[4];
    assign led_eth_yel_o   = led_r[5];
    assign led_can_grn_o   = led_r[6];
    assign irq_o           = irq_r;
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;

    // ---------------- assertions ----------------
    a_pwr_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        led_pwr_grn_o == $past(s_supply))
        else $error("power lamp does not follow supply");
    a_run_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        led_run_grn_o == $past(s_run))
        else $error("program lamp does not follow run state");
    a_err_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !s_prg_err && !s_hw_fault |=> !led_err_red_o)
        else $error("error lamp lit without error");
    a_err_slow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_prg_err && !s_hw_fault && !ctrl_r[CTRL_FAST_ERR] |=> led_err_red_o == $past(slow_ph_r))
        else $error("error lamp not on slow blink");
    a_err_steady: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_hw_fault |=> led_err_red_o)
        else $error("error lamp not steady on fault");
    a_fast_half: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(fast_ph_r) |-> $past(fast_cnt_r) == TIMER_W'(FAST_HALF - 1))
        else $error("fast blink half period wrong");
    a_card_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !s_card_in || s_card_fail |=> !led_card_grn_o)
        else $error("card lamp lit without card");
    a_card_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_card_in && !s_card_fail && !s_card_busy |=> led_card_grn_o)
        else $error("idle card lamp not steady");
    a_fbus_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !s_fb_link |=> !led_fbus_yel_o)
        else $error("fieldbus lamp lit without link");
    a_eth_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !s_eth_link |=> !led_eth_yel_o)
        else $error("ethernet lamp lit without link");
    a_can_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_can == 2'(CAN_OPERATIONAL) |=> led_can_grn_o)
        else $error("can lamp not steady in operational");
    a_flash_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(flash_ph_r) |-> $past(flash_cnt_r) == TIMER_W'(FLASH_ON - 1))
        else $error("single flash on time wrong");
    a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        irq_o == $past(|(irq_stat_r & irq_mask_r)))
        else $error("interrupt does not follow masked status");

    c_err_blink: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        s_prg_err && $rose(led_err_red_o));
    c_card_xfer: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        s_card_busy && $fell(led_card_grn_o));
    c_can_flash: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        s_can == 2'(CAN_STOPPED) && $rose(led_can_grn_o));
    c_irq_fire: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));

endmodule

`default_nettype wire

// File: bench/panel_lamp_observer.sv
// operator-side view of one panel lamp: length of its last lit and dark spells
`timescale 1ns/1ps
`default_nettype none

module panel_lamp_observer
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // lamp drive, high = lit
    input  wire logic        lamp_i,
    // last complete spells in clock cycles
    output logic      [31:0] lit_len_o,
    output logic      [31:0] dark_len_o
);
    logic        lamp_r;
    logic [31:0] run_r;

    // a spell is only reported once it has ended, so partial spells never show
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            lamp_r     <= 1'b0;
            run_r      <= 32'h0;
            lit_len_o  <= 32'h0;
            dark_len_o <= 32'h0;
        end
        else if (lamp_i === lamp_r)
        begin
            run_r <= run_r + 32'h1;
        end
        else
        begin
            if (lamp_r)
                lit_len_o <= run_r;
            else
                dark_len_o <= run_r;
            run_r  <= 32'h1;
            lamp_r <= lamp_i;
        end
    end
endmodule
`default_nettype wire

// File: bench/test_status_led_indicator_driver.sv
// self-checking bench for the status indicator driver
`timescale 1ns/1ps
`default_nettype none

module test_status_led_indicator_driver;
    import status_led_pkg::*;
    // short counts keep the run brief
    localparam int SH = 4;
    localparam int FH = 2;
    localparam int FON = 3;
    localparam int FOFF = 6;

    logic        clk_i;
    logic        rst_n_i;
    logic [13:0] cond;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq_o;
    logic [6:0]  lamps;
    logic [31:0] err_lit, err_dark, card_lit, card_dark;
    logic [31:0] fbus_lit, fbus_dark, can_lit, can_dark;
    logic [31:0] rdata;
    logic [13:0] corner [9];
    int          miscompares;
    int          tests_run;
    integer      seed;

    always #50 clk_i = ~clk_i;

    status_led_indicator_driver #(.SLOW_HALF(SH), .FAST_HALF(FH), .FLASH_ON(FON),
        .FLASH_OFF(FOFF)) status_led_indicator_driver_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .supply_ok_i(cond[0]), .prog_run_i(cond[1]),
        .prog_err_i(cond[2]), .hw_fault_i(cond[3]), .memory_card_present_i(cond[4]),
        .memory_card_busy_i(cond[5]), .memory_card_fail_i(cond[6]),
        .fbus_link_i(cond[7]), .fbus_slave_cfg_i(cond[8]), .fbus_xfer_i(cond[9]),
        .eth_link_i(cond[10]), .eth_active_i(cond[11]), .can_state_i(cond[13:12]),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .led_pwr_grn_o(lamps[0]),
        .led_run_grn_o(lamps[1]), .led_err_red_o(lamps[2]), .led_card_grn_o(lamps[3]),
        .led_fbus_yel_o(lamps[4]), .led_eth_yel_o(lamps[5]), .led_can_grn_o(lamps[6]),
        .irq_o(irq_o));

    panel_lamp_observer obs_err (.clk_i(clk_i), .rst_n_i(rst_n_i), .lamp_i(lamps[2]),
        .lit_len_o(err_lit), .dark_len_o(err_dark));
    panel_lamp_observer obs_card (.clk_i(clk_i), .rst_n_i(rst_n_i), .lamp_i(lamps[3]),
        .lit_len_o(card_lit), .dark_len_o(card_dark));
    panel_lamp_observer obs_fbus (.clk_i(clk_i), .rst_n_i(rst_n_i), .lamp_i(lamps[4]),
        .lit_len_o(fbus_lit), .dark_len_o(fbus_dark));
    panel_lamp_observer obs_can (.clk_i(clk_i), .rst_n_i(rst_n_i), .lamp_i(lamps[6]),
        .lit_len_o(can_lit), .dark_len_o(can_dark));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // holds the request until waitrequest is seen low at a rising edge
    task automatic bus_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge clk_i);
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            check(32'h1, 32'h0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] addr, input logic [31:0] exp);
        bus_xfer(1'b0, addr, 32'h0);
        check(rdata, exp);
    endtask

    function automatic logic [31:0] status_exp();
        return {22'h0, cond[13:12], cond[10], cond[9], cond[7], cond[4], cond[3:0]};
    endfunction

    // lamp modes: 0 dark, 1 steady, 2 blinking
    function automatic logic [31:0] exp_mode(input int idx);
        case (idx)
            2: return cond[3] ? 32'h1 : (cond[2] ? 32'h2 : 32'h0);
            3: return (!cond[4] || cond[6]) ? 32'h0 : (cond[5] ? 32'h2 : 32'h1);
            4: return !cond[7] ? 32'h0 : ((cond[8] && cond[9]) ? 32'h2 : 32'h1);
            5: return !cond[10] ? 32'h0 : (cond[11] ? 32'h2 : 32'h1);
            6: return (cond[13:12] == 2'h3) ? 32'h0 : ((cond[13:12] == 2'h2) ? 32'h1 : 32'h2);
            default: return {31'h0, cond[idx]};
        endcase
    endfunction

    function automatic logic [31:0] cls(input int cnt);
        return (cnt == 0) ? 32'h0 : ((cnt == 24) ? 32'h1 : 32'h2);
    endfunction

    // a 24 cycle window spans at least two periods of every pattern
    task automatic window_check();
        int cnt [7];
        repeat (6) @(posedge clk_i);
        foreach (cnt[i]) cnt[i] = 0;
        repeat (24)
        begin
            @(posedge clk_i);
            for (int i = 0; i < 7; i++) cnt[i] += (lamps[i] === 1'b1);
        end
        check(cls(cnt[0]), exp_mode(0));
        check(cls(cnt[1]), exp_mode(1));
        check(cls(cnt[2]), exp_mode(2));
        check(cls(cnt[3]), exp_mode(3));
        check(cls(cnt[4]), exp_mode(4));
        check(cls(cnt[5]), exp_mode(5));
        check(cls(cnt[6]), exp_mode(6));
        rd(ADDR_STATUS, status_exp());
    endtask

    initial
    begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        cond = 14'h0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        miscompares = 0;
        tests_run = 0;
        seed = 32'hFB38;
        corner = '{14'h000F, 14'h0000, 14'h3000, 14'h2000, 14'h0070, 14'h0080,
                   14'h0180, 14'h0400, 14'h0C00};
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_MASK, 32'h0);
        rd(ADDR_IRQ, 32'h0);
        rd(4'h2, 32'h0);
        bus_xfer(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
        rd(ADDR_STATUS, status_exp());
        // interrupt: raise, mask off, clear
        bus_xfer(1'b1, ADDR_MASK, 32'h1 << EV_PRG_ERR);
        @(posedge clk_i);
        cond <= 14'h0004;
        repeat (6) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        rd(ADDR_IRQ, 32'h1 << EV_PRG_ERR);
        bus_xfer(1'b1, ADDR_MASK, 32'h0);
        repeat (2) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd(ADDR_IRQ, 32'h1 << EV_PRG_ERR);
        bus_xfer(1'b1, ADDR_IRQ, 32'h1 << EV_PRG_ERR);
        rd(ADDR_IRQ, 32'h0);
        // exact pattern timing on slow, fast and flash generators
        @(posedge clk_i);
        cond <= 14'h03B4;
        repeat (40) @(posedge clk_i);
        check(err_lit, SH);
        check(err_dark, SH);
        check(fbus_lit, SH);
        check(fbus_dark, SH);
        check(card_lit, FH);
        check(card_dark, FH);
        check(can_lit, FON);
        check(can_dark, FOFF);
        repeat (16)
        begin
            @(posedge clk_i);
            check({31'h0, lamps[2]}, {31'h0, lamps[4]});
        end
        bus_xfer(1'b1, ADDR_CTRL, 32'h1 << CTRL_FAST_ERR);
        @(posedge clk_i);
        cond <= 14'h13B4;
        repeat (40) @(posedge clk_i);
        check(err_lit, FH);
        check(err_dark, FH);
        check(can_lit, SH);
        check(can_dark, SH);
        foreach (corner[i])
        begin
            @(posedge clk_i);
            cond <= corner[i];
            window_check();
        end
        repeat (16)
        begin
            @(posedge clk_i);
            cond <= 14'($random(seed));
            window_check();
        end
        test_done();
    end

    initial
    begin
        #3_000_000;
        miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
